/* bench/sar_host_model.sv */
// Host controller model: drives select and the serial clock, captures serial data.
`timescale 1ns/1ps
module sar_host_model #(
  parameter int HALF = 6,
  parameter int GAP = 1250
) (
  // Clock.
  input wire logic mclk_i,
  // Link to the device.
  input wire logic sdata_i,
  input wire logic sdata_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o
);
  logic [40:0] data_q;
  logic [40:0] oe_n_q;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // The serial clock idles low and only runs inside a frame.
  task automatic frame(input int falls);
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (HALF) @(negedge mclk_i);
    for (int i = 1; i <= falls; i++) begin
      sclk_o = 1'b1;
      repeat (HALF) @(negedge mclk_i);
      sclk_o = 1'b0;
      repeat (HALF) @(negedge mclk_i);
      data_q[i] = sdata_i;
      oe_n_q[i] = sdata_oe_n_i;
    end
  endtask

  // Holding select high for the rest of the period keeps starts below the maximum rate.
  task automatic deselect();
    @(negedge mclk_i);
    cs_n_o = 1'b1;
    repeat (GAP) @(negedge mclk_i);
  endtask
endmodule

/* bench/test_sar_adc_serial.sv */
// Self-checking bench for the serial converter core.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_sar_adc_serial;
  import sar_adc_pkg::*;
  logic mclk_i, nrst_i, cs_n, sclk, sdata, oe_n, sample, apd, dpd, done, cmp;
  logic [11:0] dac;
  logic [11:0] result;
  logic [11:0] vin;
  int failures, num_checks, cycles;

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Ideal comparator: keep the trial bit while the input is at or above it.
  assign cmp = (vin >= dac);

  sar_adc_serial DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .cs_n_i(cs_n),
    .serial_bit_clock_i(sclk), .sdata_o(sdata), .sdata_oe_n_o(oe_n), .cmp_i(cmp),
    .sample_o(sample), .dac_code_o(dac), .analog_pd_o(apd), .digital_pd_o(dpd),
    .result_o(result), .done_o(done));

  sar_host_model host (.mclk_i(mclk_i), .sdata_i(sdata), .sdata_oe_n_i(oe_n),
    .cs_n_o(cs_n), .sclk_o(sclk));

  task automatic conclude();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Full frame with extra clocks past the end of the repeated tail.
  task automatic full_conv(input logic [11:0] v);
    vin = v;
    host.frame(30);
    `CHK(host.oe_n_q[1], 1'b1)
    `CHK(host.oe_n_q[2], 1'b0)
    `CHK(host.data_q[2], 1'b0)
    for (int i = 3; i <= 26; i++) `CHK(host.oe_n_q[i], 1'b0)
    for (int i = 3; i <= 14; i++) `CHK(host.data_q[i], v[14-i])
    for (int i = 15; i <= 26; i++) `CHK(host.data_q[i], v[i-15])
    for (int i = 27; i <= 30; i++) `CHK(host.oe_n_q[i], 1'b1)
    `CHK(result, v)
    `CHK(done, 1'b1)
    `CHK(apd, 1'b1)
    `CHK(dpd, 1'b0)
    host.deselect();
    `CHK(dpd, 1'b1)
    `CHK(oe_n, 1'b1)
    $display("test full conversion %h done", v);
  endtask

  // Select is raised after eight result bits; the last full result must survive.
  task automatic short_cycle(input logic [11:0] v, input logic [11:0] last);
    vin = v;
    host.frame(10);
    for (int i = 3; i <= 10; i++) `CHK(host.data_q[i], v[14-i])
    `CHK(dac, (v & 12'hff0) | 12'h008)
    `CHK(apd, 1'b0)
    `CHK(oe_n, 1'b0)
    host.deselect();
    `CHK(oe_n, 1'b1)
    `CHK(apd, 1'b1)
    `CHK(dpd, 1'b1)
    `CHK(done, 1'b0)
    `CHK(result, last)
    $display("test short cycle %h done", v);
  endtask

  // Select is raised while the input is still being sampled.
  task automatic sample_abort();
    host.frame(1);
    `CHK(sample, 1'b1)
    `CHK(oe_n, 1'b1)
    `CHK(apd, 1'b0)
    host.deselect();
    `CHK(sample, 1'b0)
    `CHK(apd, 1'b1)
    $display("test sample abort done");
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    nrst_i = 1'b0;
    vin = 12'h000;
    repeat (6) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    `CHK(oe_n, 1'b1)
    `CHK(dpd, 1'b1)
    short_cycle(12'h5a3, CODE_ZERO);
    sample_abort();
    full_conv(CODE_ZERO);
    full_conv(CODE_MID);
    full_conv(CODE_MID_M1);
    full_conv(CODE_FULL);
    short_cycle(12'h3c6, CODE_FULL);
    full_conv(12'ha5c);
    conclude();
  end
endmodule

/* rtl/sar_adc_pkg.sv */
// Shared constants for the serial successive-approximation converter core.
package sar_adc_pkg;
  localparam int RES_BITS = 12;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_MID_M1 = 12'h7ff;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  // Falling serial clock edges spent sampling before the low lead bit.
  localparam logic [4:0] SAMPLE_EDGES = 5'h02;
  // Number of repeated bits in the LSB-first tail.
  localparam logic [4:0] REPEAT_BITS = 5'h0c;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 4;
endpackage

/* rtl/sar_adc_serial.sv */
`timescale 1ns/1ps
// Digital side of a 12-bit serial successive-approximation converter.
// Behaviour
// [R1] Result is 12-bit unsigned straight binary.
// [R2] Power down at completion or select high.
// [R3] Analog off both cases; digital off only deselected.
// [R4] Each bit output as soon as decided.
// [R5] Select high aborts conversion, full power-down.
// [R6] One bit decision per serial clock cycle.
// [R7] Host should clock fast, deselect otherwise.
// [R8] Host starts conversions at most 200kHz.
// [R9] Scaled scheme: select high 1 of 16.
// [R10] Output changes on serial clock falling edge.
// [R11] Two sample edges, low bit, 12 bits MSB first.
// [R12] Then LSB-first repeat, then high impedance.
// [R13] New conversion needs select high then low.
// [R14] Deselected: output off, sequencer reset.
module sar_adc_serial
  import sar_adc_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // Clock, reset and clock enable.
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Host link.
  input wire logic cs_n_i,
  input wire logic serial_bit_clock_i,
  output logic sdata_o,
  output logic sdata_oe_n_o,
  // Analog front end.
  input wire logic cmp_i,
  output logic sample_o,
  output logic [WIDTH-1:0] dac_code_o,
  output logic analog_pd_o,
  output logic digital_pd_o,
  output logic [WIDTH-1:0] result_o,
  output logic done_o
);
  typedef enum logic [2:0] {IDLE, SAMPLE, LEAD, MSB_OUT, LSB_OUT, DONE} phase_t;

  phase_t phase;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic sck_prev;
  logic fall_edge;
  logic cs_n;
  logic [4:0] cnt;
  logic [WIDTH-1:0] sar;
  logic [3:0] bit_idx;
  logic wr_en;
  logic clr_mem;
  logic [3:0] rd_idx;
  logic rd_bit;

  if (WIDTH != RES_BITS) begin : g_width_check
    $error("sar_adc_serial: only a 12-bit result is supported");
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Select and serial clock come from the host domain.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      sck_prev <= 1'b0;
    end else if (ce_i) begin
      cs_sync <= {cs_sync[0], cs_n_i};
      sck_sync <= {sck_sync[0], serial_bit_clock_i};
      sck_prev <= sck_sync[1];
    end
  end
  assign cs_n = cs_sync[1];
  assign fall_edge = sck_prev & ~sck_sync[1];

  function automatic logic [WIDTH-1:0] trial_code(input logic [WIDTH-1:0] kept, input logic [3:0] idx);
    trial_code = kept | (WIDTH'(1) << idx);
  endfunction

  // Sequencer: one phase step per falling serial clock edge.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= IDLE;
      cnt <= 5'h00;
      sar <= '0;
    end else if (ce_i) begin
      if (cs_n) begin
        phase <= IDLE; // [R5] [R14]
        cnt <= 5'h00;
        sar <= '0;
      end else if (fall_edge) begin
        unique case (phase)
          IDLE: begin
            phase <= SAMPLE; // [R13]
            cnt <= 5'h01;
          end
          SAMPLE: begin
            if (cnt == SAMPLE_EDGES - 5'h01) begin
              phase <= LEAD; // [R11]
              cnt <= 5'(WIDTH - 1);
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          LEAD: begin
            sar <= trial_code('0, cnt[3:0]) & (cmp_i ? '1 : ~(WIDTH'(1) << cnt[3:0])); // [R6]
            phase <= MSB_OUT;
          end
          MSB_OUT: begin
            if (cnt == 5'h00) begin
              phase <= LSB_OUT; // [R12]
              cnt <= 5'h01;
            end else begin
              sar <= trial_code(sar, cnt[3:0] - 4'h1) & (cmp_i ? '1 : ~(WIDTH'(1) << (cnt[3:0] - 4'h1))); // [R6]
              cnt <= cnt - 5'h01;
            end
          end
          LSB_OUT: begin
            if (cnt == REPEAT_BITS) begin
              phase <= DONE; // [R12]
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          DONE: phase <= DONE; // [R13]
          default: phase <= IDLE;
        endcase
      end
    end
  end

  // The decided bit of the current position is written as it is made.
  assign bit_idx = (phase == LEAD) ? 4'(WIDTH - 1) : cnt[3:0] - 4'h1;
  assign wr_en = ~cs_n & fall_edge & ((phase == LEAD) | (phase == MSB_OUT && cnt != 5'h00));
  assign clr_mem = cs_n;
  // The tail starts with the lowest bit, so the read index trails the count by one.
  assign rd_idx = (phase == LSB_OUT) ? cnt[3:0] - 4'h1 : 4'h0; // [R12]

  sar_result_store #(.WIDTH(WIDTH)) u_store (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .clr_i(clr_mem),
    .wr_i(wr_en),
    .wr_idx_i(bit_idx),
    .wr_bit_i(cmp_i),
    .rd_idx_i(rd_idx),
    .rd_bit_o(rd_bit),
    .word_o()
  );

  // Output pin: driven from the lead bit until the last repeated bit.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sdata_o <= 1'b0;
      sdata_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (cs_n || phase == DONE || phase == IDLE || phase == SAMPLE) begin
        sdata_o <= 1'b0;
        sdata_oe_n_o <= 1'b1; // [R14] [R12]
      end else if (phase == LEAD) begin
        sdata_o <= 1'b0; // [R11] [R10]
        sdata_oe_n_o <= 1'b0;
      end else if (phase == MSB_OUT) begin
        sdata_o <= sar[cnt[3:0]]; // [R4] [R10]
        sdata_oe_n_o <= 1'b0;
      end else begin
        sdata_o <= rd_bit; // [R12]
        sdata_oe_n_o <= 1'b0;
      end
    end
  end

  // Analog front end and power state.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_o <= 1'b0;
      dac_code_o <= '0;
      analog_pd_o <= 1'b1;
      digital_pd_o <= 1'b1;
      result_o <= CODE_ZERO;
      done_o <= 1'b0;
    end else if (ce_i) begin
      sample_o <= ~cs_n & (phase == IDLE || phase == SAMPLE);
      dac_code_o <= (phase == LEAD) ? CODE_MID : trial_code(sar, cnt[3:0] - 4'h1); // [R1]
      analog_pd_o <= cs_n | (phase == LSB_OUT) | (phase == DONE); // [R2] [R3]
      digital_pd_o <= cs_n; // [R3]
      done_o <= ~cs_n & ((phase == LSB_OUT) | (phase == DONE));
      if (phase == MSB_OUT && cnt == 5'h00 && !cs_n) begin
        result_o <= sar; // [R1]
      end
    end
  end

  a_deselect_tristate: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R14]
    (ce_i && cs_n) |=> sdata_oe_n_o) else $error("output driven while deselected");

  a_digital_pd: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R3]
    ce_i |=> (digital_pd_o == $past(cs_n))) else $error("digital power state wrong");

  a_analog_pd_desel: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R2]
    (ce_i && cs_n) |=> analog_pd_o) else $error("analog not powered down");

  a_abort_idle: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R5]
    (ce_i && cs_n) |=> (phase == IDLE)) else $error("conversion not aborted");

  sequence lead_edge;
    ce_i && !cs_n && fall_edge && phase == LEAD;
  endsequence
  a_lead_low: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R11]
    (ce_i && !cs_n && phase == LEAD) |=> (!sdata_oe_n_o && !sdata_o)) else $error("lead bit not low");

  a_one_decision: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R6]
    lead_edge |=> (phase == MSB_OUT && cnt == 5'(WIDTH - 1))) else $error("bit step wrong");

  a_done_hold: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R12] [R13]
    (ce_i && !cs_n && phase == DONE) |=> (phase == DONE && sdata_oe_n_o)) else $error("done not held");

  a_fall_only: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R10]
    (ce_i && !cs_n && !fall_edge && phase != IDLE) |=> $stable(phase)) else $error("phase moved off edge");
endmodule

/* rtl/sar_result_store.sv */
`timescale 1ns/1ps
// Small result memory: holds the SAR register bits, read data registered.
module sar_result_store
  import sar_adc_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Write port.
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic wr_bit_i,
  // Read port.
  input wire logic [3:0] rd_idx_i,
  output logic rd_bit_o,
  output logic [WIDTH-1:0] word_o
);
  logic [WIDTH-1:0] mem;

  // The write index is four bits wide, so no more than 16 bits can be held.
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("sar_result_store: WIDTH out of range");
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        mem <= '0;
      end else if (wr_i) begin
        mem[wr_idx_i] <= wr_bit_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_bit_o <= 1'b0;
    end else if (ce_i) begin
      rd_bit_o <= mem[rd_idx_i];
    end
  end

  assign word_o = mem;
endmodule
